// *** pao_port.v ***
`timescale 1ns/1ps
`include "pao_defs.vh"

// Digital output side of a pipelined converter. The quantised sample
// arrives as a signed offset from midscale; this block clamps, delays,
// codes and presents it on the parallel result bus.
module pao_port (
  // Clock and reset
  input wire i_mclk,
  input wire i_reset,
  // Quantised sample from the analog front end, signed from midscale
  input wire [`PAO_AIN_MSB:0] i_sample,
  // Static controls
  input wire i_format_select,
  input wire i_standby_control,
  // Receiver handshake
  input wire i_result_ready,
  // Result bus
  output wire [`PAO_RES_MSB:0] o_result_bus,
  output wire o_result_valid,
  output wire o_over_range,
  output wire o_under_range,
  // Status
  output wire o_standby_active,
  output wire o_sample_missed
);

  // Stage 0: raw capture
  reg [`PAO_AIN_MSB:0] raw_q;
  reg raw_valid_q;
  // Stages 1..5: clamped code, range flags and valid
  reg [`PAO_STG_W-1:0] stg_q [1:`PAO_LAST_STG];
  reg standby_q;
  reg missed_q;
  integer k;

  // Buffer interface
  wire buf_in_ready;
  wire buf_out_valid;
  wire [`PAO_WORD_W-1:0] buf_out_data;
  wire [`PAO_WORD_W-1:0] buf_in_data;
  wire buf_in_valid;

  // Clamp arithmetic
  wire [`PAO_SUM_MSB:0] sum_w;
  reg [`PAO_RES_MSB:0] code_d;
  reg ovr_d;
  reg und_d;
  wire [`PAO_RES_MSB:0] last_code_w;
  wire [`PAO_RES_MSB:0] coded_w;

  // The whole pipe moves only when the buffer can take a word, so a
  // long receiver stall pauses sampling rather than losing a result.
  wire advance_w;
  assign advance_w = buf_in_ready;

  // Shift sample onto the 0..1023 scale, sign-extended to avoid wrap
  assign sum_w = {raw_q[`PAO_AIN_MSB], raw_q} + `PAO_MIDSCALE;

  // Saturating clamp of the shifted sample
  always @* begin
    code_d = sum_w[`PAO_RES_MSB:0];
    ovr_d = 1'b0;
    und_d = 1'b0;
    if (sum_w[`PAO_SUM_MSB]) begin
      code_d = `PAO_CODE_MIN; // see RQ9
      und_d = 1'b1;
    end else if (sum_w[`PAO_SUM_MSB-1:`PAO_RES_W] != 2'h0) begin
      code_d = `PAO_CODE_MAX; // see RQ8
      ovr_d = 1'b1;
    end
  end

  // Stage 0 sampling; standby blocks new samples, pipe still drains
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      raw_q <= `PAO_RAW_RST;
      raw_valid_q <= 1'b0;
    end else if (advance_w) begin
      raw_q <= i_sample; // see RQ3
      raw_valid_q <= !i_standby_control; // see RQ6
    end
  end

  // Stages 1..5: clamp once, then fixed delay to the buffer input
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      for (k = 1; k <= `PAO_LAST_STG; k = k + 1) begin
        stg_q[k] <= `PAO_STG_RST;
      end
    end else if (advance_w) begin
      stg_q[1] <= {raw_valid_q, und_d, ovr_d, code_d}; // see RQ1
      for (k = 2; k <= `PAO_LAST_STG; k = k + 1) begin
        stg_q[k] <= stg_q[k-1]; // see RQ4
      end
    end
  end

  // Coding applied last, so a format change hits whole words only
  assign last_code_w = stg_q[`PAO_LAST_STG][`PAO_RES_MSB:0];
  assign coded_w = {last_code_w[`PAO_RES_MSB] ^ i_format_select,
                    last_code_w[`PAO_RES_MSB-1:0]}; // see RQ5, see RQ10
  assign buf_in_data = {stg_q[`PAO_LAST_STG][`PAO_UND_BIT],
                        stg_q[`PAO_LAST_STG][`PAO_OVR_BIT],
                        coded_w};
  assign buf_in_valid = stg_q[`PAO_LAST_STG][`PAO_VLD_BIT];

  // Output register is the sixth flop after the sampling edge
  pao_skid #(
    .WIDTH(`PAO_WORD_W)
  ) u_skid (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_in_valid(buf_in_valid),
    .i_in_data(buf_in_data),
    .o_in_ready(buf_in_ready),
    .o_out_valid(buf_out_valid),
    .o_out_data(buf_out_data),
    .i_out_ready(i_result_ready)
  );

  // Status flops; a missed edge is one where sampling had to pause
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      standby_q <= 1'b0;
      missed_q <= 1'b0;
    end else begin
      standby_q <= i_standby_control; // see RQ6
      missed_q <= !advance_w && !i_standby_control;
    end
  end

  // Bit 0 is the LSB, bit 9 the MSB
  assign o_result_bus = buf_out_data[`PAO_RES_MSB:0]; // see RQ7
  assign o_over_range = buf_out_data[`PAO_OVR_BIT];
  assign o_under_range = buf_out_data[`PAO_UND_BIT];
  assign o_result_valid = buf_out_valid;
  assign o_standby_active = standby_q;
  assign o_sample_missed = missed_q;

endmodule

// *** pao_defs.vh ***
// Behaviour
// RQ1 - Each sample becomes one 10-bit word, one word per clock up to 65 MHz.
// RQ2 - The capture side keeps the sampling clock between 10 and 65 MHz.
// RQ3 - One sample is taken on every rising clock edge while active; the code skips edges while the output buffer is full.
// RQ4 - A sample's word appears on the result bus six edges after sampling.
// RQ5 - Format select high gives two's complement, low gives offset binary.
// RQ6 - Standby control high halts conversion; low keeps converting.
// RQ7 - Result bus bit 0 is the LSB, bit 9 the MSB.
// RQ8 - Inputs above full scale saturate at code 1023, never wrapping.
// RQ9 - Inputs below full scale saturate at code 0, never wrapping.
// RQ10 - Two's complement equals offset binary with the MSB inverted.
`ifndef PAO_DEFS_VH
`define PAO_DEFS_VH

// Widths
`define PAO_RES_W 10
`define PAO_RES_MSB 9
`define PAO_AIN_W 12
`define PAO_AIN_MSB 11
`define PAO_SUM_W 13
`define PAO_SUM_MSB 12
// Carried word: flag bits sit above the result code
`define PAO_WORD_W 12
`define PAO_OVR_BIT 10
`define PAO_UND_BIT 11
// Stage word adds a valid bit on top
`define PAO_STG_W 13
`define PAO_VLD_BIT 12

// Codes
`define PAO_MIDSCALE 13'h0200
`define PAO_CODE_MAX 10'h03ff
`define PAO_CODE_MIN 10'h0000
`define PAO_RAW_RST 12'h0000
`define PAO_STG_RST 13'h0000
`define PAO_WORD_RST 12'h0000

// Timing: stages before the output buffer register
`define PAO_LATENCY 6
`define PAO_LAST_STG 5
`define PAO_FMAX_MHZ 65
`define PAO_FMIN_MHZ 10

`endif

// *** pao_skid.v ***
`timescale 1ns/1ps
`include "pao_defs.vh"

// Two-entry buffer: output register plus one skid register
module pao_skid #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_reset,
  // Filling side
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  // Draining side
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);

  reg [WIDTH-1:0] out_data_q;
  reg out_valid_q;
  reg [WIDTH-1:0] skid_data_q;
  reg skid_valid_q;
  reg in_ready_q;

  // Ready is registered so the source never sees a combinational path
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      out_data_q <= {WIDTH{1'b0}};
      out_valid_q <= 1'b0;
      skid_data_q <= {WIDTH{1'b0}};
      skid_valid_q <= 1'b0;
      in_ready_q <= 1'b1;
    end else if (in_ready_q) begin
      if (i_in_valid && out_valid_q && !i_out_ready) begin
        // Receiver stalled: park the word instead of losing it
        skid_data_q <= i_in_data;
        skid_valid_q <= 1'b1;
        in_ready_q <= 1'b0;
      end else if (!out_valid_q || i_out_ready) begin
        out_data_q <= i_in_data;
        out_valid_q <= i_in_valid;
      end
    end else if (i_out_ready) begin
      // Drain the parked word, then reopen the filling side
      out_data_q <= skid_data_q;
      out_valid_q <= 1'b1;
      skid_valid_q <= 1'b0;
      in_ready_q <= 1'b1;
    end
  end

  assign o_in_ready = in_ready_q;
  assign o_out_valid = out_valid_q;
  assign o_out_data = out_data_q;

endmodule

// *** pao_exp.svh ***
`ifndef PAO_EXP_SVH
`define PAO_EXP_SVH
// Expected code: clamp offset from midscale, flip MSB for signed form
function automatic logic [9:0] pao_exp(logic [11:0] s, logic f);
  int v;
  v = $signed(s) + 512;
  v = v > 1023 ? 1023 : (v < 0 ? 0 : v);
  return v[9:0] ^ {f, 9'h000};
endfunction
`endif

// *** pao_port_assertions.sv ***
`timescale 1ns/1ps
`include "pao_exp.svh"
module pao_port_chk (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Controls, receiver handshake and input sample
  input wire logic i_format_select,
  input wire logic i_standby_control,
  input wire logic i_result_ready,
  input wire logic [11:0] i_sample,
  // Result side
  input wire logic [9:0] o_result_bus,
  input wire logic o_result_valid,
  input wire logic o_over_range,
  input wire logic o_under_range,
  // Status
  input wire logic o_standby_active,
  input wire logic o_sample_missed
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // Sample with the receiver ready up to and at its output edge
  sequence s_flow;
    i_result_ready[*4] ##0 !i_standby_control ##1 i_result_ready[*6];
  endsequence
  // Extra margin so buffered and in-flight words can drain
  sequence s_idle;
    i_standby_control && i_result_ready;
  endsequence
  a_six_valid: assert property (s_flow |=> o_result_valid)
    else $error("word late");
  a_code_match: assert property (s_flow |=>
    o_result_bus == pao_exp($past(i_sample, 7), $past(i_format_select)))
    else $error("bad code");
  a_over_flag: assert property (s_flow |=>
    o_over_range == ($signed($past(i_sample, 7)) > 511)) else $error("over");
  a_under_flag: assert property (s_flow |=>
    o_under_range == ($signed($past(i_sample, 7)) < -512)) else $error("under");
  a_standby_idle: assert property (s_idle[*8] ##1 s_idle[*4]
    |=> !o_result_valid) else $error("word in standby");
  a_hold_word: assert property (o_result_valid && !i_result_ready
    |=> o_result_valid && $stable(o_result_bus)) else $error("word lost");
  a_miss_cause: assert property (o_sample_missed
    |-> !$past(i_standby_control) && !$past(i_result_ready, 2))
    else $error("false miss");
  a_flow_no_miss: assert property (i_result_ready[*3]
    |=> !o_sample_missed) else $error("miss in flow");
  a_standby_echo: assert property (!$past(i_reset)
    |-> o_standby_active == $past(i_standby_control))
    else $error("standby status wrong");
  c_over: cover property (o_over_range && o_result_valid);
  c_under: cover property (o_under_range && o_result_valid);
  c_stall: cover property (o_sample_missed);
endmodule
bind pao_port pao_port_chk u_pao_port_chk (.i_mclk(i_mclk),
  .i_reset(i_reset), .i_format_select(i_format_select),
  .i_standby_control(i_standby_control), .i_result_ready(i_result_ready),
  .i_sample(i_sample), .o_result_bus(o_result_bus),
  .o_result_valid(o_result_valid), .o_over_range(o_over_range),
  .o_under_range(o_under_range), .o_standby_active(o_standby_active),
  .o_sample_missed(o_sample_missed));

// *** pao_capture.sv ***
`timescale 1ns/1ps
module pao_capture (
  // Clock and stall command
  input wire logic i_mclk,
  input wire logic i_stall,
  // Word from the converter
  input wire logic i_valid,
  input wire logic [9:0] i_word,
  output wire logic o_ready
);
  logic [9:0] got [$];
  logic ready_q = 1'b1;
  assign o_ready = ready_q;
  // Capture accepted words; ready only moves just after an edge
  always @(posedge i_mclk) begin
    if (i_valid === 1'b1 && ready_q) got.push_back(i_word);
    ready_q <= #1 !i_stall;
  end
endmodule

// *** tb_pao_port.sv ***
`timescale 1ns/1ps
`include "pao_exp.svh"
module tb_pao_port;
  logic i_mclk = 0, i_reset = 1, i_format_select = 0, stall = 0;
  logic i_standby_control = 1, i_result_ready, o_result_valid;
  logic o_over_range, o_under_range, o_standby_active, o_sample_missed;
  logic [11:0] i_sample = 12'h0000;
  logic [9:0] o_result_bus;
  int bad_count = 0, samples_checked = 0, nmiss = 0;
  // Midscale, both ends, then above and below full scale
  logic [11:0] tv [5] = '{12'h0000, 12'h0e00, 12'h01ff, 12'h0258, 12'h0d44};
  pao_port u_pao_port (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_sample(i_sample), .i_format_select(i_format_select),
    .i_standby_control(i_standby_control), .i_result_ready(i_result_ready),
    .o_result_bus(o_result_bus), .o_result_valid(o_result_valid),
    .o_over_range(o_over_range), .o_under_range(o_under_range),
    .o_standby_active(o_standby_active), .o_sample_missed(o_sample_missed));
  pao_capture u_pao_capture (.i_mclk(i_mclk), .i_stall(stall),
    .i_valid(o_result_valid), .i_word(o_result_bus), .o_ready(i_result_ready));
  // 62.5 MHz keeps the sampling clock inside its legal band
  initial forever #8 i_mclk = ~i_mclk;
  // Count skipped edges away from the rising edge
  always @(negedge i_mclk) if (o_sample_missed === 1'b1) nmiss++;
  task automatic check(string n, logic [9:0] seen, logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Five samples in one format, then idle and compare arrivals
  task automatic t_format(logic f);
    int b = u_pao_capture.got.size();
    i_format_select = f;
    foreach (tv[k]) begin
      @(posedge i_mclk);
      #1 i_standby_control = 0;
      i_sample = tv[k];
    end
    @(posedge i_mclk);
    #1 i_standby_control = 1;
    repeat (12) @(posedge i_mclk);
    #1;
    check("count", 10'(u_pao_capture.got.size() - b), 10'h005);
    foreach (tv[k])
      check("word", u_pao_capture.got[b + k],
        pao_exp(tv[k], f));
  endtask
  // Input moves in standby, yet nothing may come out
  task automatic t_standby();
    int b = u_pao_capture.got.size();
    repeat (10) begin
      @(posedge i_mclk);
      #1 i_sample = i_sample + 12'h0011;
    end
    check("standby", 10'(u_pao_capture.got.size() - b), 10'h000);
  endtask
  // Receiver stalls mid-stream: every edge is a word or a miss
  task automatic t_stall();
    int b = u_pao_capture.got.size();
    int m = nmiss;
    i_sample = 12'h0064;
    i_standby_control = 0;
    repeat (8) @(posedge i_mclk);
    #1 stall = 1;
    repeat (6) @(posedge i_mclk);
    #1 stall = 0;
    repeat (6) @(posedge i_mclk);
    #1 i_standby_control = 1;
    repeat (14) @(posedge i_mclk);
    #1;
    check("taken", 10'(u_pao_capture.got.size() - b + nmiss - m),
      10'h014);
    // Format select is still high from the previous scenario
    for (int k = b; k < u_pao_capture.got.size(); k++)
      check("held", u_pao_capture.got[k],
        pao_exp(12'h0064, i_format_select));
  endtask
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_mclk);
    #1 i_reset = 0;
    t_format(1'b0);
    t_format(1'b1);
    t_standby();
    t_stall();
    complete_run();
  end
  // Hang guard, far beyond the ~82 cycles needed
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
endmodule
